// *** design/ive_entry.sv ***
// interrupt source gating, arbitration and hardware entry sequence
//
// Function
// - gate each maskable source by master and own enable
// - watchdog is unmaskable, priority 1, vector 0008H
// - fetch vector entry, then run shift cycle
// - highest setting level first, then fixed priority
// - maskable accepted only while master enable is 1
// - maskable entry saves pc, segment, status to level one
// - maskable entry clears master enable, level 1, loads pc
// - software trap enters like maskable, vector from instruction
// - serial fifo source priority 14, vector 0022H
// - uart fifo source priority 19, vector 002CH
// - slow clock switch source priority 26, vector 003AH
// - sar converter source priority 29, vector 0040H
// - rc converter source priority 30, vector 0042H
// - function timer 3 priority 48, vector 0066H
// - time base 2 lowest priority 55, vector 0074H
`timescale 1ns/1ps
`default_nettype none

module ive_entry (
  input  wire logic                                        clk,
  input  wire logic                                        rst_n,
  // peripheral side
  input  wire logic [ive_pkg::NSRC-1:0]                    src_irq,
  input  wire logic [ive_pkg::NSRC-1:0]                    src_clr,
  input  wire logic [ive_pkg::NSRC-1:0]                    per_source_enable_regs,
  input  wire logic [ive_pkg::NSRC-1:0][ive_pkg::LVL_W-1:0] src_level,
  input  wire logic                                        watchdog_nmi_source,
  input  wire logic                                        wdt_clr,
  // core side
  input  wire logic                                        core_boundary,
  input  wire ive_pkg::ive_ctx_s                           cur_ctx,
  input  wire logic                                        software_trap_instr,
  input  wire logic [ive_pkg::PC_W-1:0]                    swi_vec_addr,
  input  wire logic                                        mie_set,
  input  wire logic                                        mie_clr,
  input  wire logic                                        exception_level_field_load,
  input  wire logic [ive_pkg::ELV_W-1:0]                   exception_level_field_value,
  input  wire logic                                        vec_valid,
  input  wire logic [ive_pkg::PC_W-1:0]                    vec_data,
  output logic                                             vec_rd,
  output logic [ive_pkg::PC_W-1:0]                         vec_addr,
  output logic                                             pc_load,
  output logic [ive_pkg::PC_W-1:0]                         pc_load_addr,
  output logic                                             entry_done,
  output logic [1:0]                                       entry_kind,
  output logic [ive_pkg::SIDX_W-1:0]                       entry_src,
  output logic                                             busy,
  output logic                                             master_irq_enable,
  output logic [ive_pkg::ELV_W-1:0]                        exception_level_field,
  output logic [ive_pkg::PC_W-1:0]                         return_addr_save_lvl1,
  output logic [ive_pkg::CSR_W-1:0]                        segment_save_lvl1,
  output logic [ive_pkg::PSW_W-1:0]                        status_save_lvl1,
  output logic [ive_pkg::PC_W-1:0]                         return_addr_save_lvl2,
  output logic [ive_pkg::CSR_W-1:0]                        segment_save_lvl2,
  output logic [ive_pkg::PSW_W-1:0]                        status_save_lvl2,
  output logic [ive_pkg::NSRC-1:0]                         pend,
  output logic                                             nmi_pend
);

  // ***********************************************
  // declarations
  // ***********************************************
  ive_pkg::ive_state_e                 st_q;
  ive_pkg::ive_state_e                 st_d;
  ive_pkg::ive_kind_e                  kind_q;
  ive_pkg::ive_kind_e                  kind_d;
  logic [ive_pkg::SIDX_W-1:0]          src_q;
  logic [ive_pkg::SIDX_W-1:0]          src_d;
  logic                                vrd_q;
  logic                                vrd_d;
  logic [ive_pkg::PC_W-1:0]            vaddr_q;
  logic [ive_pkg::PC_W-1:0]            vaddr_d;
  logic                                pcl_q;
  logic                                pcl_d;
  logic [ive_pkg::PC_W-1:0]            pca_q;
  logic [ive_pkg::PC_W-1:0]            pca_d;
  logic                                done_q;
  logic                                done_d;
  logic [1:0]                          dkind_q;
  logic [1:0]                          dkind_d;
  logic [ive_pkg::SIDX_W-1:0]          dsrc_q;
  logic [ive_pkg::SIDX_W-1:0]          dsrc_d;
  logic                                busy_q;
  logic                                busy_d;
  logic                                hold_q;
  logic                                hold_d;
  logic [ive_pkg::NSRC-1:0]            pend_q;
  logic [ive_pkg::NSRC-1:0]            pend_d;
  logic [ive_pkg::NSRC-1:0]            req_en;
  logic                                nmi_q;
  logic                                nmi_d;
  logic                                mie_q;
  logic                                mie_d;
  logic [ive_pkg::ELV_W-1:0]           elv_q;
  logic [ive_pkg::ELV_W-1:0]           elv_d;
  ive_pkg::ive_ctx_s                   sav1_q;
  ive_pkg::ive_ctx_s                   sav1_d;
  ive_pkg::ive_ctx_s                   sav2_q;
  ive_pkg::ive_ctx_s                   sav2_d;
  logic                                win_valid;
  logic [ive_pkg::SIDX_W-1:0]          win_idx;
  logic                                shift_mask;
  logic                                shift_nmi;
  logic                                shift_lvl1;

  // ***********************************************
  // vector address of a maskable source
  // ***********************************************
  function automatic logic [ive_pkg::PC_W-1:0] vec_of(
    input logic [ive_pkg::SIDX_W-1:0] idx
  );
    logic [ive_pkg::PC_W-1:0] v;
    v = '0;
    if (idx < ive_pkg::SIDX_W'(ive_pkg::NSRC)) begin
      v = ive_pkg::VEC_BASE + {7'h00, ive_pkg::SRC_PRIO[idx], 1'b0};
    end
    case (idx)
      ive_pkg::SRC_SERIAL_FIFO: v = ive_pkg::VEC_SERIAL_FIFO;
      ive_pkg::SRC_UART_FIFO:   v = ive_pkg::VEC_UART_FIFO;
      ive_pkg::SRC_SLOW_CLK:    v = ive_pkg::VEC_SLOW_CLK;
      ive_pkg::SRC_SAR_ADC:     v = ive_pkg::VEC_SAR_ADC;
      ive_pkg::SRC_RC_ADC:      v = ive_pkg::VEC_RC_ADC;
      ive_pkg::SRC_FTIMER3:     v = ive_pkg::VEC_FTIMER3;
      ive_pkg::SRC_TBASE2:      v = ive_pkg::VEC_TBASE2;
      default:                  v = v;
    endcase
    return v;
  endfunction : vec_of

  // ***********************************************
  // pending flags and gating
  // ***********************************************
  // the shift cycle retires the flag of the source being entered
  assign shift_mask = (st_q == ive_pkg::ST_SHIFT) && (kind_q == ive_pkg::KIND_MASK);
  assign shift_nmi  = (st_q == ive_pkg::ST_SHIFT) && (kind_q == ive_pkg::KIND_NMI);
  assign shift_lvl1 = shift_mask || ((st_q == ive_pkg::ST_SHIFT) &&
                                     (kind_q == ive_pkg::KIND_SWI));

  // per source: a new request wins over clear or service in the same cycle
  for (genvar g = 0; g < ive_pkg::NSRC; g++) begin : g_src
    assign pend_d[g] = src_irq[g] |
                       (pend_q[g] & ~src_clr[g] &
                        ~(shift_mask && (src_q == ive_pkg::SIDX_W'(g))));
    assign req_en[g] = pend_q[g] & per_source_enable_regs[g] & mie_q;
  end

  // watchdog flag: no enable of any kind sits in its path
  always_comb begin
    nmi_d = watchdog_nmi_source | (nmi_q & ~wdt_clr & ~shift_nmi);
  end

  // pending registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pend_q <= '0;
      nmi_q  <= 1'b0;
    end else begin
      pend_q <= pend_d;
      nmi_q  <= nmi_d;
    end
  end

  // ***********************************************
  // arbitration
  // ***********************************************
  // losing requests keep their flags and compete again later
  ive_arb u_arb (
    .req   (req_en),
    .level (src_level),
    .valid (win_valid),
    .idx   (win_idx)
  );

  // ***********************************************
  // entry sequencer
  // ***********************************************
  // idle -> fetch vector -> shift cycle; one entry in flight at a time
  always_comb begin
    st_d    = st_q;
    kind_d  = kind_q;
    src_d   = src_q;
    vrd_d   = vrd_q;
    vaddr_d = vaddr_q;
    pcl_d   = 1'b0;
    pca_d   = pca_q;
    done_d  = 1'b0;
    dkind_d = dkind_q;
    dsrc_d  = dsrc_q;
    busy_d  = busy_q;
    hold_d  = hold_q;
    case (st_q)
      ive_pkg::ST_IDLE: begin
        if (core_boundary && hold_q) begin
          hold_d = 1'b0; // first handler instruction runs unbroken
        end else if (core_boundary && nmi_q) begin
          kind_d  = ive_pkg::KIND_NMI;
          src_d   = '0;
          vaddr_d = ive_pkg::VEC_WDT;
          vrd_d   = 1'b1;
          busy_d  = 1'b1;
          st_d    = ive_pkg::ST_FETCH;
        end else if (core_boundary && software_trap_instr) begin
          kind_d  = ive_pkg::KIND_SWI;
          src_d   = '0;
          vaddr_d = swi_vec_addr;
          vrd_d   = 1'b1;
          busy_d  = 1'b1;
          st_d    = ive_pkg::ST_FETCH;
        end else if (core_boundary && win_valid) begin
          kind_d  = ive_pkg::KIND_MASK;
          src_d   = win_idx;
          vaddr_d = vec_of(win_idx);
          vrd_d   = 1'b1;
          busy_d  = 1'b1;
          st_d    = ive_pkg::ST_FETCH;
        end
      end
      ive_pkg::ST_FETCH: begin
        // table read stays requested until the core returns the entry
        if (vec_valid) begin
          vrd_d = 1'b0;
          pca_d = vec_data;
          st_d  = ive_pkg::ST_SHIFT;
        end
      end
      ive_pkg::ST_SHIFT: begin
        pcl_d   = 1'b1;
        done_d  = 1'b1;
        dkind_d = kind_q;
        dsrc_d  = src_q;
        busy_d  = 1'b0;
        hold_d  = 1'b1;
        kind_d  = ive_pkg::KIND_NONE;
        st_d    = ive_pkg::ST_IDLE;
      end
      default: begin
        st_d   = ive_pkg::ST_IDLE;
        vrd_d  = 1'b0;
        busy_d = 1'b0;
        kind_d = ive_pkg::KIND_NONE;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q    <= ive_pkg::ST_IDLE;
      kind_q  <= ive_pkg::KIND_NONE;
      src_q   <= '0;
      vrd_q   <= 1'b0;
      vaddr_q <= '0;
      pcl_q   <= 1'b0;
      pca_q   <= '0;
      done_q  <= 1'b0;
      dkind_q <= '0;
      dsrc_q  <= '0;
      busy_q  <= 1'b0;
      hold_q  <= 1'b0;
    end else begin
      st_q    <= st_d;
      kind_q  <= kind_d;
      src_q   <= src_d;
      vrd_q   <= vrd_d;
      vaddr_q <= vaddr_d;
      pcl_q   <= pcl_d;
      pca_q   <= pca_d;
      done_q  <= done_d;
      dkind_q <= dkind_d;
      dsrc_q  <= dsrc_d;
      busy_q  <= busy_d;
      hold_q  <= hold_d;
    end
  end

  // ***********************************************
  // saved context, master enable, exception level
  // ***********************************************
  // the shift cycle overrides a core update of a field it writes in the same cycle; a watchdog shift leaves master enable to the core
  always_comb begin
    sav1_d = sav1_q;
    sav2_d = sav2_q;
    mie_d  = mie_q;
    elv_d  = elv_q;
    if (mie_set) begin
      mie_d = 1'b1;
    end else if (mie_clr) begin
      mie_d = 1'b0;
    end
    if (exception_level_field_load) begin
      elv_d = exception_level_field_value;
    end
    if (shift_lvl1) begin
      sav1_d = cur_ctx;
      mie_d  = 1'b0;
      elv_d  = ive_pkg::ELV_MASK;
    end else if (shift_nmi) begin
      sav2_d = cur_ctx;
      elv_d  = ive_pkg::ELV_NMI;
    end
  end

  // context registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sav1_q <= '0;
      sav2_q <= '0;
      mie_q  <= ive_pkg::MIE_RST;
      elv_q  <= ive_pkg::ELV_RST;
    end else begin
      sav1_q <= sav1_d;
      sav2_q <= sav2_d;
      mie_q  <= mie_d;
      elv_q  <= elv_d;
    end
  end

  // ***********************************************
  // outputs, all straight from registers
  // ***********************************************
  assign vec_rd                = vrd_q;
  assign vec_addr              = vaddr_q;
  assign pc_load               = pcl_q;
  assign pc_load_addr          = pca_q;
  assign entry_done            = done_q;
  assign entry_kind            = dkind_q;
  assign entry_src             = dsrc_q;
  assign busy                  = busy_q;
  assign master_irq_enable     = mie_q;
  assign exception_level_field = elv_q;
  assign return_addr_save_lvl1 = sav1_q.pc;
  assign segment_save_lvl1     = sav1_q.code_segment_reg;
  assign status_save_lvl1      = sav1_q.processor_status_word;
  assign return_addr_save_lvl2 = sav2_q.pc;
  assign segment_save_lvl2     = sav2_q.code_segment_reg;
  assign status_save_lvl2      = sav2_q.processor_status_word;
  assign pend                  = pend_q;
  assign nmi_pend              = nmi_q;

endmodule : ive_entry

`default_nettype wire

// *** design/ive_pkg.sv ***
// shared constants, source table and types for the interrupt vectoring entry block
package ive_pkg;

  // ***********************************************
  // widths
  // ***********************************************
  localparam int NSRC   = 37; // maskable sources
  localparam int PC_W   = 16;
  localparam int CSR_W  = 4;
  localparam int PSW_W  = 8;
  localparam int LVL_W  = 2;  // setting level width
  localparam int ELV_W  = 2;  // exception level width
  localparam int SIDX_W = 6;  // source index width

  // ***********************************************
  // reset values and level codes
  // ***********************************************
  localparam logic             MIE_RST  = 1'b0;
  localparam logic [ELV_W-1:0] ELV_RST  = 2'h0;
  localparam logic [ELV_W-1:0] ELV_MASK = 2'h1;
  localparam logic [ELV_W-1:0] ELV_NMI  = 2'h2;

  // ***********************************************
  // vector table
  // ***********************************************
  localparam logic [PC_W-1:0] VEC_BASE        = 16'h0006;
  localparam logic [7:0]      WDT_PRIO        = 8'h01;
  localparam logic [PC_W-1:0] VEC_WDT         = 16'h0008;
  localparam logic [PC_W-1:0] VEC_SERIAL_FIFO = 16'h0022;
  localparam logic [PC_W-1:0] VEC_UART_FIFO   = 16'h002C;
  localparam logic [PC_W-1:0] VEC_SLOW_CLK    = 16'h003A;
  localparam logic [PC_W-1:0] VEC_SAR_ADC     = 16'h0040;
  localparam logic [PC_W-1:0] VEC_RC_ADC      = 16'h0042;
  localparam logic [PC_W-1:0] VEC_FTIMER3     = 16'h0066;
  localparam logic [PC_W-1:0] VEC_TBASE2      = 16'h0074;

  // source indices of the named entries (index 0 is the highest priority)
  localparam logic [SIDX_W-1:0] SRC_SERIAL_FIFO = 6'h09;
  localparam logic [SIDX_W-1:0] SRC_UART_FIFO   = 6'h0E;
  localparam logic [SIDX_W-1:0] SRC_SLOW_CLK    = 6'h0F;
  localparam logic [SIDX_W-1:0] SRC_SAR_ADC     = 6'h12;
  localparam logic [SIDX_W-1:0] SRC_RC_ADC      = 6'h13;
  localparam logic [SIDX_W-1:0] SRC_FTIMER3     = 6'h21;
  localparam logic [SIDX_W-1:0] SRC_TBASE2      = 6'h24;

  // fixed priority number of each maskable source, in index order
  localparam logic [7:0] SRC_PRIO [NSRC] = '{
    8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C,
    8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h13, 8'h1A,
    8'h1B, 8'h1C, 8'h1D, 8'h1E, 8'h21, 8'h22, 8'h25, 8'h26,
    8'h27, 8'h28, 8'h29, 8'h2A, 8'h2B, 8'h2C, 8'h2D, 8'h2E,
    8'h2F, 8'h30, 8'h35, 8'h36, 8'h37
  };

  // ***********************************************
  // types
  // ***********************************************
  typedef struct packed {
    logic [PC_W-1:0]  pc;
    logic [CSR_W-1:0] code_segment_reg;
    logic [PSW_W-1:0] processor_status_word;
  } ive_ctx_s;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_FETCH = 3'h2,
    ST_SHIFT = 3'h4
  } ive_state_e;

  typedef enum logic [1:0] {
    KIND_NONE = 2'h0,
    KIND_MASK = 2'h1,
    KIND_NMI  = 2'h2,
    KIND_SWI  = 2'h3
  } ive_kind_e;

endpackage : ive_pkg

// *** design/ive_arb.sv ***
// winner selection among enabled maskable requests
`timescale 1ns/1ps
`default_nettype none

module ive_arb (
  input  wire logic [ive_pkg::NSRC-1:0]                    req,
  input  wire logic [ive_pkg::NSRC-1:0][ive_pkg::LVL_W-1:0] level,
  output logic                                             valid,
  output logic [ive_pkg::SIDX_W-1:0]                       idx
);

  // scan from lowest rank upward; ">=" lets the lower index win a level tie
  always_comb begin
    logic [ive_pkg::LVL_W-1:0] best;
    best  = '0;
    valid = 1'b0;
    idx   = '0;
    for (int i = ive_pkg::NSRC - 1; i >= 0; i--) begin
      if (req[i] && (!valid || level[i] >= best)) begin
        valid = 1'b1;
        best  = level[i];
        idx   = ive_pkg::SIDX_W'(i);
      end
    end
  end

endmodule : ive_arb

`default_nettype wire

// *** verif/ive_entry_asserts.sv ***
// concurrent checks on the ports of the entry block
`timescale 1ns/1ps
`default_nettype none

module ive_entry_asserts (
  input wire logic                      clk,
  input wire logic                      rst_n,
  input wire ive_pkg::ive_ctx_s         cur_ctx,
  input wire logic                      software_trap_instr,
  input wire logic [ive_pkg::NSRC-1:0]  src_clr,
  input wire logic                      wdt_clr,
  input wire logic                      vec_valid,
  input wire logic [ive_pkg::PC_W-1:0]  vec_data,
  input wire logic                      vec_rd,
  input wire logic [ive_pkg::PC_W-1:0]  vec_addr,
  input wire logic                      pc_load,
  input wire logic [ive_pkg::PC_W-1:0]  pc_load_addr,
  input wire logic                      entry_done,
  input wire logic [1:0]                entry_kind,
  input wire logic                      busy,
  input wire logic                      master_irq_enable,
  input wire logic [ive_pkg::ELV_W-1:0] exception_level_field,
  input wire logic [ive_pkg::PC_W-1:0]  return_addr_save_lvl1,
  input wire logic [ive_pkg::PSW_W-1:0] status_save_lvl1,
  input wire logic [ive_pkg::PC_W-1:0]  return_addr_save_lvl2,
  input wire logic [ive_pkg::PSW_W-1:0] status_save_lvl2,
  input wire logic [ive_pkg::NSRC-1:0]  pend,
  input wire logic                      nmi_pend
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // vector returned, read released, then a single load cycle
  sequence fetch_end_s;
    vec_valid && vec_rd;
  endsequence
  sequence shift_s;
    !vec_rd ##1 (pc_load && entry_done) ##1 !pc_load;
  endsequence
  property lvl1_entry_p(logic [1:0] k);
    entry_done && entry_kind == k |-> !master_irq_enable
      && exception_level_field == ive_pkg::ELV_MASK
      && return_addr_save_lvl1 == $past(cur_ctx.pc)
      && status_save_lvl1 == $past(cur_ctx.processor_status_word);
  endproperty

  shift_cycle_a: assert property (fetch_end_s |=> shift_s)
    else $error("shift cycle out of step");
  load_addr_a: assert property (pc_load |-> pc_load_addr == $past(vec_data, 2))
    else $error("handler address not the fetched entry");
  wdt_vec_a: assert property ($rose(vec_rd) && $past(nmi_pend) |-> vec_addr == ive_pkg::VEC_WDT)
    else $error("watchdog vector wrong");
  mie_gate_a: assert property ($rose(busy) && !$past(nmi_pend) && !$past(software_trap_instr)
    |-> $past(master_irq_enable))
    else $error("maskable taken with master enable off");
  mask_entry_a: assert property (lvl1_entry_p(2'h1))
    else $error("maskable entry state wrong");
  trap_entry_a: assert property (lvl1_entry_p(2'h3))
    else $error("trap entry state wrong");
  nmi_entry_a: assert property (entry_done && entry_kind == 2'h2 |-> exception_level_field == ive_pkg::ELV_NMI
    && $stable(master_irq_enable) && return_addr_save_lvl2 == $past(cur_ctx.pc)
    && status_save_lvl2 == $past(cur_ctx.processor_status_word))
    else $error("watchdog entry state wrong");
  pend_hold_a: assert property ((($past(pend) & ~pend & ~$past(src_clr)) != '0)
    |-> entry_done && entry_kind == 2'h1)
    else $error("pending flag dropped unserviced");
  nmi_hold_a: assert property ($fell(nmi_pend) |-> (entry_done && entry_kind == 2'h2) || $past(wdt_clr))
    else $error("watchdog pending dropped unserviced");
endmodule : ive_entry_asserts

`default_nettype wire

// *** verif/ive_core_model.sv ***
// core-side model answering vector table reads
`timescale 1ns/1ps
`default_nettype none

module ive_core_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        vec_rd,
  input  wire logic [15:0] vec_addr,
  input  wire logic [3:0]  wait_cycles,
  output logic             vec_valid,
  output logic [15:0]      vec_data
);
  logic [3:0] cnt_q;
  logic       served_q;

  // answers after wait_cycles; out of reset, data toggles whenever it is not valid, and reset holds it at 5A5A
  always_ff @(posedge clk) begin
    vec_data <= rst_n ? ~vec_data : 16'h5A5A;
    if (!rst_n || !vec_rd) begin
      cnt_q     <= 4'h0;
      served_q  <= 1'b0;
      vec_valid <= 1'b0;
    end else if (vec_valid) begin
      vec_valid <= 1'b0;
      served_q  <= 1'b1;
    end else if (!served_q && cnt_q == wait_cycles) begin
      vec_valid <= 1'b1;
      vec_data  <= {4'hC, vec_addr[11:0]};
    end else if (!served_q) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule : ive_core_model

`default_nettype wire

// *** verif/ive_entry_bench.sv ***
// self-checking bench for the interrupt entry block
`timescale 1ns/1ps
`default_nettype none

module ive_entry_bench;
  logic clk, rst_n, watchdog_nmi_source, wdt_clr, core_boundary, software_trap_instr;
  logic mie_set, mie_clr, exception_level_field_load, vec_valid, vec_rd, pc_load, entry_done, busy;
  logic master_irq_enable, nmi_pend;
  logic [36:0]      src_irq, src_clr, per_source_enable_regs, pend;
  logic [36:0][1:0] src_level;
  logic [15:0]      swi_vec_addr, vec_data, vec_addr, pc_load_addr;
  logic [15:0]      return_addr_save_lvl1, return_addr_save_lvl2;
  logic [1:0]       exception_level_field_value, entry_kind, exception_level_field;
  logic [5:0]       entry_src;
  logic [3:0]       segment_save_lvl1, segment_save_lvl2, wait_cycles;
  logic [7:0]       status_save_lvl1, status_save_lvl2;
  ive_pkg::ive_ctx_s cur_ctx;
  int num_errors = 0;
  int num_checks = 0;
  int          nidx [7] = '{9, 14, 15, 18, 19, 33, 36};
  logic [15:0] nvec [7] = '{16'h0022, 16'h002C, 16'h003A, 16'h0040, 16'h0042, 16'h0066, 16'h0074};

  ive_entry      uut (.*);
  ive_core_model core (.*);

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize

  task automatic bnd();
    @(posedge clk) core_boundary <= 1'b1;
    @(posedge clk) core_boundary <= 1'b0;
  endtask : bnd

  // one-cycle source, watchdog and master enable pulses
  task automatic drive(input logic [36:0] m, input logic wd, input logic me);
    @(posedge clk);
    src_irq             <= m;
    watchdog_nmi_source <= wd;
    mie_set             <= me;
    @(posedge clk);
    src_irq             <= '0;
    watchdog_nmi_source <= 1'b0;
    mie_set             <= 1'b0;
  endtask : drive

  // boundary that must not start an entry
  task automatic probe();
    bnd();
    repeat (4) @(negedge clk) chk("busy", busy, 1'b0);
    @(posedge clk);
  endtask : probe

  // full entry, then the ignored boundary of the handler's first instruction
  task automatic enter(input logic [1:0] k, input logic [15:0] va, input logic [5:0] s);
    int n;
    logic [15:0] got;
    n = 0;
    @(posedge clk) cur_ctx <= {va ^ 16'h8421, va[3:0], va[7:0] ^ 8'h3C};
    bnd();
    @(negedge clk) got = vec_addr;
    chk("fetch", {busy, vec_rd}, 2'h3);
    while (entry_done !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    if (n == 40) begin
      num_errors++;
      summarize();
    end
    chk("vector", got, va);
    chk("kind", entry_kind, k);
    chk("source", entry_src, s);
    chk("handler", pc_load_addr, {4'hC, va[11:0]});
    chk("shift", {busy, vec_rd, pc_load}, 3'h1);
    if (k == 2'h2) begin
      chk("save2", {return_addr_save_lvl2, segment_save_lvl2, status_save_lvl2}, cur_ctx);
      chk("level", exception_level_field, 2'h2);
    end else begin
      chk("save1", {return_addr_save_lvl1, segment_save_lvl1, status_save_lvl1}, cur_ctx);
      chk("mie", master_irq_enable, 1'b0);
      chk("level", exception_level_field, 2'h1);
    end
    bnd();
  endtask : enter

  task automatic t_reset();
    @(negedge clk) chk("reset", {master_irq_enable, exception_level_field, pend}, 40'h0);
    @(posedge clk);
    $display("test reset done");
  endtask : t_reset

  // every maskable source in turn, with varying answer delay
  task automatic t_vectors();
    logic [15:0] va;
    for (int i = 0; i < 37; i++) begin
      va = 16'h0006 + {7'h0, ive_pkg::SRC_PRIO[i], 1'b0};
      for (int j = 0; j < 7; j++) begin
        if (i == nidx[j]) va = nvec[j];
      end
      wait_cycles <= 4'(i % 4);
      drive(37'h1 << i, 1'b0, 1'b1);
      enter(2'h1, va, 6'(i));
    end
    $display("test vectors done");
  endtask : t_vectors

  // setting level first, then index; losers stay pending
  task automatic t_priority();
    src_level[5]  <= 2'h2;
    src_level[30] <= 2'h2;
    src_level[3]  <= 2'h1;
    drive(37'h1 << 30 | 37'h28, 1'b0, 1'b1);
    enter(2'h1, 16'h001A, 6'd5);
    chk("pend", {pend[30], pend[3]}, 2'h3);
    drive('0, 1'b0, 1'b1);
    enter(2'h1, 16'h0060, 6'd30);
    drive('0, 1'b0, 1'b1);
    enter(2'h1, 16'h0016, 6'd3);
    src_level <= '0;
    $display("test priority done");
  endtask : t_priority

  task automatic t_mask();
    drive('0, 1'b0, 1'b1);
    mie_clr <= 1'b1;
    @(posedge clk) mie_clr <= 1'b0;
    drive(37'h80, 1'b0, 1'b0);
    probe();
    chk("pend7", pend[7], 1'b1);
    per_source_enable_regs[7] <= 1'b0;
    drive('0, 1'b0, 1'b1);
    probe();
    per_source_enable_regs[7] <= 1'b1;
    enter(2'h1, 16'h001E, 6'd7);
    drive(37'h100, 1'b0, 1'b0);
    src_clr[8] <= 1'b1;
    @(posedge clk) src_clr[8] <= 1'b0;
    @(negedge clk) chk("pend8", pend[8], 1'b0);
    @(posedge clk);
    $display("test masking done");
  endtask : t_mask

  // watchdog beats a pending maskable and leaves master enable alone
  task automatic t_nmi();
    drive(37'h4, 1'b1, 1'b1);
    enter(2'h2, 16'h0008, 6'd0);
    chk("mie", master_irq_enable, 1'b1);
    enter(2'h1, 16'h0014, 6'd2);
    $display("test watchdog done");
  endtask : t_nmi

  task automatic t_swi();
    drive(37'h1, 1'b0, 1'b1);
    software_trap_instr <= 1'b1;
    swi_vec_addr        <= 16'h00A0;
    enter(2'h3, 16'h00A0, 6'd0);
    software_trap_instr <= 1'b0;
    drive('0, 1'b0, 1'b1);
    enter(2'h1, 16'h0010, 6'd0);
    $display("test trap done");
  endtask : t_swi

  // watchdog with master enable off, watchdog flag clear, core level load
  task automatic t_ctrl();
    drive('0, 1'b1, 1'b0);
    enter(2'h2, 16'h0008, 6'd0);
    chk("mie", master_irq_enable, 1'b0);
    drive('0, 1'b1, 1'b0);
    wdt_clr <= 1'b1;
    @(negedge clk) chk("nmi set", nmi_pend, 1'b1);
    @(posedge clk) wdt_clr <= 1'b0;
    @(negedge clk) chk("nmi clr", nmi_pend, 1'b0);
    @(posedge clk) exception_level_field_load <= 1'b1;
    exception_level_field_value <= 2'h3;
    @(posedge clk) exception_level_field_load <= 1'b0;
    @(negedge clk) chk("exception_level_field", exception_level_field, 2'h3);
    drive(37'h1, 1'b0, 1'b1);
    enter(2'h1, 16'h0010, 6'd0);
    $display("test control done");
  endtask : t_ctrl

  // reset, scenarios, verdict
  initial begin
    {rst_n, watchdog_nmi_source, wdt_clr, core_boundary, software_trap_instr} = '0;
    {mie_set, mie_clr, exception_level_field_load, exception_level_field_value} = '0;
    {src_irq, src_clr, src_level} = '0;
    per_source_enable_regs = '1;
    cur_ctx = '0;
    swi_vec_addr = '0;
    wait_cycles = 4'h0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_vectors();
    t_priority();
    t_mask();
    t_nmi();
    t_swi();
    t_ctrl();
    summarize();
  end
endmodule : ive_entry_bench

bind ive_entry ive_entry_asserts chk_i (.*);

`default_nettype wire
